/* File: hdl/asrc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Both strobes driven low to start write.
// - Data held stable across terminating strobe rise.
// - Write pulse covers float delay plus setup.
// - Address loaded on the same clock edge that chip select falls.
// - No data driven while device drives lines.
// - Write enable held high during reads.
// - Read with select, output enable low.
module asrc_host
  import asrc_pkg::*;
#(
  parameter int AW = asrc_pkg::ADDR_W,
  parameter int DW = asrc_pkg::DATA_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [AW-1:0] reqAddr,
  input wire logic [DW-1:0] reqData,
  output logic reqReady,
  output logic rspValid,
  output logic [DW-1:0] rspData,
  output logic [AW-1:0] addressLines,
  output logic chipSelN,
  output logic outEnN,
  output logic writeEnN,
  input wire logic [DW-1:0] dataLinesIn,
  output logic [DW-1:0] dataLinesOut,
  output logic [DW-1:0] dataLinesOeN
);
  import asrc_pkg::*;

  asrc_state_e state;
  asrc_state_e next_state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [DW-1:0] dataSync;

  // Read data comes from the pins, so it is resynchronised
  asrc_sync2 #(.WIDTH(DW)) uDataSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(dataLinesIn),
    .dout(dataSync)
  );

  wire logic accept = reqReady && reqValid;
  wire logic countDone = (count == CNT_ZERO);
  wire logic [CNT_W-1:0] countDec = count - CNT_ONE;
  // Two sync stages plus the access time
  wire logic [CNT_W-1:0] readLoad = READ_CNT + 4'h2;

  always_comb begin
    next_state = state;
    next_count = countDec;
    case (state)
      ST_IDLE: begin
        next_count = CNT_ZERO;
        if (accept) begin
          next_state = reqWrite ? ST_WR_SETUP : ST_RD_SETUP;
        end
      end
      ST_RD_SETUP: begin
        next_state = ST_RD_WAIT;
        next_count = readLoad;
      end
      ST_RD_WAIT: begin
        if (countDone) begin
          next_state = ST_GAP;
          next_count = GAP_CNT;
        end
      end
      ST_WR_SETUP: begin
        next_state = ST_WR_PULSE;
        next_count = WRITE_CNT;
      end
      ST_WR_PULSE: begin
        if (countDone) begin
          next_state = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        next_state = ST_GAP;
        next_count = GAP_CNT;
      end
      ST_GAP: begin
        if (countDone) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_count = CNT_ZERO;
      end
    endcase
  end

  // Strobe and pin levels for the next state
  wire logic nextSel = (next_state != ST_IDLE) && (next_state != ST_GAP);
  wire logic nextRd = (next_state == ST_RD_SETUP) || (next_state == ST_RD_WAIT);
  wire logic nextWrPulse = (next_state == ST_WR_PULSE);
  wire logic nextWrDrive = (next_state == ST_WR_SETUP) || nextWrPulse
                           || (next_state == ST_WR_HOLD);
  wire logic readDone = (state == ST_RD_WAIT) && countDone;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      count <= CNT_ZERO;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
      addressLines <= '0;
      chipSelN <= 1'b1;
      outEnN <= 1'b1;
      writeEnN <= 1'b1;
      dataLinesOut <= '0;
      dataLinesOeN <= '1;
    end else begin
      state <= next_state;
      count <= next_count;
      reqReady <= (next_state == ST_IDLE) && !accept;
      rspValid <= readDone;
      if (readDone) begin
        rspData <= dataSync;
      end
      if (accept) begin
        addressLines <= reqAddr;
        dataLinesOut <= reqData;
      end
      chipSelN <= !nextSel;
      outEnN <= !nextRd;
      writeEnN <= !nextWrPulse;
      dataLinesOeN <= {DW{!nextWrDrive}};
    end
  end
endmodule : asrc_host
`default_nettype wire

/* File: hdl/asrc_pkg.sv */
package asrc_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  // Pin timing, slowest speed grade, in ns
  localparam int T_ACCESS_NS = 15;
  localparam int T_WRITE_PULSE_NS = 10;
  localparam int T_WE_TO_FLOAT_NS = 7;
  localparam int T_DATA_SETUP_NS = 8;
  localparam int T_ADDR_SETUP_NS = 8;
  localparam int T_DESELECT_POWERDOWN_NS = 15;
  localparam int READ_CYCLES = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES =
    (T_WE_TO_FLOAT_NS + T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYCLES =
    (T_DESELECT_POWERDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYCLES);
  localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYCLES);
  localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(GAP_CYCLES);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD, ST_GAP
  } asrc_state_e;
endpackage : asrc_pkg

/* File: hdl/asrc_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module asrc_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : asrc_sync2
`default_nettype wire

/* File: tb/asrc_host_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module asrc_host_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic [16:0] addressLines,
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic writeEnN,
  input wire logic [7:0] dataLinesOut,
  input wire logic [7:0] dataLinesOeN
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wr_start_a: assert property ($fell(writeEnN) |-> !chipSelN)
    else $error("write strobe without select");
  data_hold_a: assert property ($rose(writeEnN) |-> $stable(dataLinesOut) && !chipSelN
    && !dataLinesOeN[0]) else $error("write data moved at write end");
  wr_len_a: assert property ($fell(writeEnN) |-> !writeEnN [*2])
    else $error("write pulse too short");
  addr_hold_a: assert property (!chipSelN && !$past(chipSelN) |-> $stable(addressLines))
    else $error("address moved while selected");
  take_sel_a: assert property (reqValid && reqReady |=> !reqReady && !chipSelN)
    else $error("request not taken");
  no_fight_a: assert property (!outEnN |-> &dataLinesOeN)
    else $error("host drives during read");
  rd_we_a: assert property (!outEnN |-> writeEnN && !chipSelN)
    else $error("write strobe during read");
  rd_rsp_a: assert property ($fell(outEnN) |-> ##[5:8] rspValid)
    else $error("no read answer");
  cover property ($rose(writeEnN));
  cover property (rspValid);
  cover property (reqValid && reqReady);
endmodule : asrc_host_checker
bind asrc_host asrc_host_checker i_chk (.*);
`default_nettype wire

/* File: tb/asrc_sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model (
  input wire logic chipSelN,
  input wire logic outEnN,
  input wire logic writeEnN,
  input wire logic [16:0] addressLines,
  input wire logic [7:0] dataLinesOut,
  input wire logic [7:0] dataLinesOeN,
  output wire logic [7:0] dataLinesIn
);
  import asrc_pkg::*;
  logic [7:0] mem [0:17'h1FFFF];
  wire logic writing = !chipSelN && !writeEnN;
  wire logic reading = !chipSelN && !outEnN && writeEnN;
  // Undriven bus shows the stored byte on a read and its inverse otherwise, contention shows unknown
  assign #(T_ACCESS_NS) dataLinesIn = !dataLinesOeN[0] ? (reading ? 8'hXX : dataLinesOut)
    : reading ? mem[addressLines] : ~mem[addressLines];
  always @(negedge writing) mem[addressLines] <= dataLinesIn;
endmodule : asrc_sram_model
`default_nettype wire

/* File: tb/async_sram_128k_x8_interface_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module async_sram_128k_x8_interface_tb;
  logic ref_clk = 0, rst_n = 0, reqValid = 0, reqWrite = 0, reqReady, rspValid;
  logic chipSelN, outEnN, writeEnN;
  logic [16:0] reqAddr = 17'h00000, addressLines;
  logic [7:0] reqData = 8'h00, rspData, dataLinesOut, dataLinesOeN;
  wire logic [7:0] dataLinesIn;
  int fails = 0, num_checks = 0;
  asrc_host i_dut (.*);
  asrc_sram_model i_mem (.*);
  initial forever #20 ref_clk = ~ref_clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'h1 && n++ < 50) @(negedge ref_clk);
    if (reqReady !== 1'h1) begin
      fails++;
      $display("MISMATCH %0t host never ready", $time);
    end
    {reqValid, reqWrite, reqAddr, reqData} = {1'h1, wr, a, d};
    @(negedge ref_clk);
    reqValid = 1'h0;
    while (!wr && rspValid !== 1'h1 && n++ < 80) @(negedge ref_clk);
    if (!wr && rspValid !== 1'h1) begin
      fails++;
      $display("MISMATCH %0t no read answer", $time);
    end
  endtask : xfer
  task automatic t_reset();
    rst_n = 1'h0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    chk({5'h00, reqReady, chipSelN, writeEnN}, 8'h07);
    xfer(1'h0, 17'h0ABCD, 8'h00);
    chk(rspData, 8'hEE);
    $display("test reset done");
  endtask : t_reset
  task automatic t_edges();
    xfer(1'h1, 17'h00000, 8'hA5);
    xfer(1'h1, 17'h1FFFF, 8'h5A);
    xfer(1'h0, 17'h00000, 8'h00);
    chk(rspData, 8'hA5);
    xfer(1'h0, 17'h1FFFF, 8'h00);
    chk(rspData, 8'h5A);
    $display("test edges done");
  endtask : t_edges
  task automatic t_overwrite();
    xfer(1'h1, 17'h0ABCD, 8'h11);
    xfer(1'h1, 17'h0ABCD, 8'hEE);
    xfer(1'h0, 17'h0ABCD, 8'h00);
    chk(rspData, 8'hEE);
    xfer(1'h0, 17'h0ABCD, 8'h00);
    chk(rspData, 8'hEE);
    $display("test overwrite done");
  endtask : t_overwrite
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'h1;
    @(negedge ref_clk);
    chk({5'h00, chipSelN, outEnN, writeEnN}, 8'h07);
    chk(dataLinesOeN, 8'hFF);
    t_edges();
    t_overwrite();
    t_reset();
    stop_test();
  end
  // Tests need well under 200 cycles
  initial begin
    #100000;
    fails++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test();
  end
endmodule : async_sram_128k_x8_interface_tb
`default_nettype wire
